// file: hdl/tid_core.sv
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - add accumulator and file, update carry, digit carry, zero; one cycle
// - byte ops: destination bit 0 writes accumulator, 1 writes the file
// - AND accumulator with file, only zero flag, result per destination bit
// - AND literal into accumulator, update zero flag
// - clear or set the selected file bit, no flags, one cycle
// - skip next instruction on selected bit clear or set; two cycles if skipping
// - decrement or increment file, skip when zero, flags unchanged
// - rotate file left or right through carry; only carry changes
// - OR or XOR accumulator with file, update zero, honour destination
// - OR or XOR literal into accumulator, update zero, one cycle
// - return from subroutine loading literal into accumulator, two cycles
// - standby and watchdog clear words update timeout and powerdown flags
// - every program counter write except branch forces its ninth bit to zero
// - port operands read the pins, not the output latch
// - direction load with operand 6 copies accumulator; 1 means pin floats
// - writing the timer register clears prescaler when assigned to timer
// - one instruction cycle spans four clock phases
// - a taken skip discards the fetched instruction and runs a no-op
module tid_core #(
  parameter int PC_W = 9,
  parameter logic [PC_W-1:0] RESET_VEC = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic clk_en,
  // program memory
  output logic [PC_W-1:0] prog_addr,
  input wire logic [tid_pkg::INSTR_W-1:0] prog_data,
  // port pins
  input wire logic [tid_pkg::GPIO_W-1:0] gpio_in,
  output tid_pkg::tid_pin_s gpio_pin,
  // system controls
  input wire logic wake_req,
  output logic standby,
  output logic wdt_clear,
  output logic prescaler_clear,
  // state view
  output tid_pkg::tid_view_s view
);
  import tid_pkg::*;

  if (PC_W < BRANCH_W) begin : g_bad_pc
    $error("tid_core: PC_W must cover the branch literal");
  end
  if (GPIO_W > DATA_W) begin : g_bad_gpio
    $error("tid_core: GPIO_W wider than data path");
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode

  function automatic tid_dec_s decode(input logic [INSTR_W-1:0] ir);
    tid_dec_s d;
    logic byte_op;
    d = '0;
    d.op = ALU_PASS;
    byte_op = 1'b0;
    casez (ir)
      OPC_NOP: d.op = ALU_PASS;
      OPC_OPTION: d.option = 1'b1;
      OPC_SLEEP: d.sleep = 1'b1;
      OPC_WDT: d.wdt = 1'b1;
      OPC_DIRECTION_LATCH_LOAD: d.direction_latch_load = 1'b1;
      OPC_MOVWF: begin
        d.op = ALU_PASS_W;
        d.wr_f = 1'b1;
      end
      OPC_CLRW: begin
        d.op = ALU_ZERO;
        d.wr_w = 1'b1;
        d.upd_z = 1'b1;
      end
      OPC_CLRF: begin
        d.op = ALU_ZERO;
        d.wr_f = 1'b1;
        d.upd_z = 1'b1;
      end
      OPC_SUB: begin
        d.op = ALU_SUB;
        byte_op = 1'b1;
        {d.upd_c, d.upd_dc, d.upd_z} = 3'h7;
      end
      OPC_ADD: begin
        d.op = ALU_ADD;
        byte_op = 1'b1;
        {d.upd_c, d.upd_dc, d.upd_z} = 3'h7;
      end
      OPC_AND: begin
        d.op = ALU_AND;
        byte_op = 1'b1;
        d.upd_z = 1'b1;
      end
      OPC_OR, OPC_XOR: begin
        d.op = ir[DEST_BIT+2] ? ALU_XOR : ALU_OR;
        byte_op = 1'b1;
        d.upd_z = 1'b1;
      end
      OPC_DEC, OPC_INC, OPC_COM, OPC_MOVF: begin
        if (!ir[INSTR_W-3]) d.op = ALU_DEC;
        else if (ir[DEST_BIT+2]) d.op = ALU_INC;
        else if (ir[DEST_BIT+1]) d.op = ALU_COM;
        else d.op = ALU_PASS;
        byte_op = 1'b1;
        d.upd_z = 1'b1;
      end
      OPC_DECSZ, OPC_INCSZ: begin
        d.op = ir[INSTR_W-4] ? ALU_INC : ALU_DEC;
        byte_op = 1'b1;
        d.skip_zero = 1'b1;
      end
      OPC_RLC, OPC_RRC: begin
        d.op = ir[DEST_BIT+1] ? ALU_RLC : ALU_RRC;
        byte_op = 1'b1;
        d.upd_c = 1'b1;
      end
      OPC_SWAP: begin
        d.op = ALU_SWAP;
        byte_op = 1'b1;
      end
      OPC_BCLR, OPC_BSET: begin
        d.op = ir[INSTR_W-4] ? ALU_BSET : ALU_BCLR;
        d.wr_f = 1'b1;
      end
      OPC_TSKC: d.skip_clr = 1'b1;
      OPC_TSKS: d.skip_set = 1'b1;
      OPC_RETL: begin
        d.op = ALU_PASS;
        d.use_lit = 1'b1;
        d.wr_w = 1'b1;
        d.ret = 1'b1;
      end
      OPC_CALL: d.call = 1'b1;
      OPC_BRANCH: d.branch = 1'b1;
      OPC_MOVL: begin
        d.use_lit = 1'b1;
        d.wr_w = 1'b1;
      end
      OPC_ORL, OPC_XORL, OPC_ANDL: begin
        d.op = ir[INSTR_W-3] ? (ir[INSTR_W-4] ? ALU_XOR : ALU_AND) : ALU_OR;
        d.use_lit = 1'b1;
        d.wr_w = 1'b1;
        d.upd_z = 1'b1;
      end
      default: d.op = ALU_PASS;
    endcase
    if (byte_op) begin
      d.wr_f = ir[DEST_BIT];
      d.wr_w = ~ir[DEST_BIT];
    end
    return d;
  endfunction : decode

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [1:0] phase_ff;
  logic [INSTR_W-1:0] ir_ff;
  logic [PC_W-1:0] pc_ff;
  logic [PC_W-1:0] stack0_ff;
  logic [PC_W-1:0] stack1_ff;
  logic [DATA_W-1:0] acc_ff;
  logic [DATA_W-1:0] status_ff;
  logic [DATA_W-1:0] fsel_ff;
  logic [DATA_W-1:0] timer_ff;
  logic [DATA_W-1:0] option_ff;
  logic [GPIO_W-1:0] latch_ff;
  logic [GPIO_W-1:0] direction_latch_load_ff;
  logic [DATA_W-1:0] ram_ff [2**FILE_AW];
  logic [GPIO_W-1:0] gpio_meta_ff;
  logic [GPIO_W-1:0] gpio_sync_ff;
  logic wake_meta_ff;
  logic wake_sync_ff;
  logic standby_ff;
  logic wdt_clear_ff;
  logic presc_clear_ff;

  tid_dec_s dec;
  logic exec;
  logic [FILE_AW-1:0] faddr;
  logic [DATA_W-1:0] fdata;
  logic [DATA_W-1:0] opd;
  logic [DATA_W-1:0] res;
  logic alu_c;
  logic alu_dc;
  logic alu_z;
  logic bit_val;
  logic skip;
  logic pc_write;
  logic flush;
  logic [PC_W-1:0] nxt_pc;
  logic [DATA_W-1:0] nxt_status;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; the first stage feeds only the second

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gpio_meta_ff <= '0;
      gpio_sync_ff <= '0;
      wake_meta_ff <= 1'b0;
      wake_sync_ff <= 1'b0;
    end else if (clk_en) begin
      gpio_meta_ff <= gpio_in;
      gpio_sync_ff <= gpio_meta_ff;
      wake_meta_ff <= wake_req;
      wake_sync_ff <= wake_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // phase counter; all execution happens in the last phase

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase_ff <= '0;
    end else if (clk_en && !standby_ff) begin
      phase_ff <= phase_ff + PHASE_STEP;
    end
  end

  assign exec = clk_en && !standby_ff && (phase_ff == PHASE_EXEC);

  ////////////////////////////////////////////////////////////////////////////
  // operand fetch and alu

  assign dec = decode(ir_ff);
  assign faddr = (ir_ff[FILE_AW-1:0] == ADDR_INDIRECT) ? fsel_ff[FILE_AW-1:0]
                                                       : ir_ff[FILE_AW-1:0];

  always_comb begin
    case (faddr)
      ADDR_INDIRECT: fdata = '0;
      ADDR_TIMER: fdata = timer_ff;
      ADDR_PCLOW: fdata = pc_ff[DATA_W-1:0];
      ADDR_STATUS: fdata = status_ff;
      ADDR_FSEL: fdata = fsel_ff;
      // pins, not the latch, so read-modify-write sees the real levels
      ADDR_GPIO: fdata = DATA_W'(gpio_sync_ff);
      default: fdata = ram_ff[faddr];
    endcase
  end

  assign opd = dec.use_lit ? ir_ff[LIT_W-1:0] : fdata;
  assign bit_val = fdata[ir_ff[BITSEL_LSB +: BITSEL_W]];

  tid_alu u_alu (
    .op(dec.op),
    .bit_sel(ir_ff[BITSEL_LSB +: BITSEL_W]),
    .opd(opd),
    .acc(acc_ff),
    .carry_in(status_ff[ST_CARRY]),
    .res(res),
    .carry(alu_c),
    .dcarry(alu_dc),
    .zero(alu_z)
  );

  assign skip = (dec.skip_zero && alu_z) || (dec.skip_clr && !bit_val)
              || (dec.skip_set && bit_val);
  assign pc_write = dec.wr_f && (faddr == ADDR_PCLOW);
  assign flush = skip || pc_write || dec.branch || dec.call || dec.ret;

  ////////////////////////////////////////////////////////////////////////////
  // program counter, instruction register and stack

  always_comb begin
    nxt_pc = pc_ff + PC_W'(1);
    if (dec.branch) begin
      nxt_pc = PC_W'(ir_ff[BRANCH_W-1:0]);
    end else if (dec.call) begin
      nxt_pc = PC_W'(ir_ff[LIT_W-1:0]);
    end else if (dec.ret) begin
      nxt_pc = stack0_ff;
      nxt_pc[LIT_W] = 1'b0;
    end else if (pc_write) begin
      nxt_pc = PC_W'(res);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pc_ff <= RESET_VEC;
      ir_ff <= NOP_WORD;
    end else if (exec) begin
      pc_ff <= nxt_pc;
      // the prefetched word is dropped whenever flow changes
      ir_ff <= flush ? NOP_WORD : prog_data;
    end
  end

  // two levels; a third call silently loses the oldest return address
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stack0_ff <= '0;
      stack1_ff <= '0;
    end else if (exec && dec.call) begin
      stack0_ff <= pc_ff;
      stack1_ff <= stack0_ff;
    end else if (exec && dec.ret) begin
      stack0_ff <= stack1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // accumulator and status

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_ff <= '0;
    end else if (exec && dec.wr_w) begin
      acc_ff <= res;
    end
  end

  // timeout and powerdown are read-only to data writes
  always_comb begin
    nxt_status = status_ff;
    if (dec.wr_f && faddr == ADDR_STATUS) begin
      nxt_status = {res[DATA_W-1:ST_TOUT+1], status_ff[ST_TOUT:ST_PDOWN],
                    res[ST_ZERO:ST_CARRY]};
    end
    if (dec.upd_z) nxt_status[ST_ZERO] = alu_z;
    if (dec.upd_c) nxt_status[ST_CARRY] = alu_c;
    if (dec.upd_dc) nxt_status[ST_DCARRY] = alu_dc;
    if (dec.sleep) begin
      nxt_status[ST_TOUT] = 1'b1;
      nxt_status[ST_PDOWN] = 1'b0;
    end
    if (dec.wdt) begin
      nxt_status[ST_TOUT] = 1'b1;
      nxt_status[ST_PDOWN] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_ff <= STATUS_RST;
    end else if (exec) begin
      status_ff <= nxt_status;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // file registers

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fsel_ff <= '0;
      timer_ff <= '0;
      latch_ff <= '0;
    end else if (exec && dec.wr_f) begin
      if (faddr == ADDR_FSEL) fsel_ff <= res;
      if (faddr == ADDR_TIMER) timer_ff <= res;
      if (faddr == ADDR_GPIO) latch_ff <= res[GPIO_W-1:0];
    end
  end

  // general purpose registers carry no reset, as in a plain ram
  // special addresses are shadowed harmlessly: their reads come from their own flops
  always_ff @(posedge clk) begin
    if (exec && dec.wr_f) begin
      ram_ff[faddr] <= res;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // option, direction latches

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      option_ff <= OPTION_RST;
      direction_latch_load_ff <= DIRECTION_LATCH_LOAD_RST;
    end else if (exec) begin
      if (dec.option) option_ff <= acc_ff;
      if (dec.direction_latch_load && ir_ff[BITSEL_W-1:0] == DIRECTION_LATCH_LOAD_PORT_SEL) begin
        direction_latch_load_ff <= acc_ff[GPIO_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // standby and one-instruction strobes

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      standby_ff <= 1'b0;
    end else if (clk_en) begin
      if (exec && dec.sleep) begin
        standby_ff <= 1'b1;
      end else if (wake_sync_ff) begin
        standby_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wdt_clear_ff <= 1'b0;
      presc_clear_ff <= 1'b0;
    end else if (clk_en) begin
      wdt_clear_ff <= exec && (dec.wdt || dec.sleep);
      presc_clear_ff <= exec && dec.wr_f && (faddr == ADDR_TIMER)
                        && !option_ff[OPT_PSA];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prog_addr = pc_ff;
  assign gpio_pin.out = latch_ff;
  assign gpio_pin.oe = ~direction_latch_load_ff;
  assign standby = standby_ff;
  assign wdt_clear = wdt_clear_ff;
  assign prescaler_clear = presc_clear_ff;
  assign view.acc = acc_ff;
  assign view.status = status_ff;
  assign view.option = option_ff;
  assign view.timer = timer_ff;

endmodule : tid_core

`default_nettype wire

// file: hdl/tid_pkg.sv
package tid_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths and field positions
  localparam int INSTR_W = 12;
  localparam int DATA_W = 8;
  localparam int FILE_AW = 5;
  localparam int GPIO_W = 6;
  localparam int NIB_W = 4;
  localparam int MSB_BIT = DATA_W - 1;
  localparam int DEST_BIT = 5;
  localparam int BITSEL_LSB = 5;
  localparam int BITSEL_W = 3;
  localparam int LIT_W = 8;
  localparam int BRANCH_W = 9;

  ////////////////////////////////////////////////////////////////////////////
  // instruction cycle timing
  localparam int PHASES = 4;
  localparam logic [1:0] PHASE_EXEC = 2'(PHASES - 1);
  localparam logic [1:0] PHASE_STEP = 2'h1;

  ////////////////////////////////////////////////////////////////////////////
  // file register addresses
  localparam logic [FILE_AW-1:0] ADDR_INDIRECT = 5'h00;
  localparam logic [FILE_AW-1:0] ADDR_TIMER = 5'h01;
  localparam logic [FILE_AW-1:0] ADDR_PCLOW = 5'h02;
  localparam logic [FILE_AW-1:0] ADDR_STATUS = 5'h03;
  localparam logic [FILE_AW-1:0] ADDR_FSEL = 5'h04;
  localparam logic [FILE_AW-1:0] ADDR_GPIO = 5'h06;
  localparam logic [2:0] DIRECTION_LATCH_LOAD_PORT_SEL = 3'h6;

  ////////////////////////////////////////////////////////////////////////////
  // status and option bits, reset values
  localparam int ST_CARRY = 0;
  localparam int ST_DCARRY = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_PDOWN = 3;
  localparam int ST_TOUT = 4;
  localparam int OPT_PSA = 3;
  localparam logic [DATA_W-1:0] STATUS_RST = 8'h18;
  localparam logic [DATA_W-1:0] OPTION_RST = 8'hff;
  localparam logic [GPIO_W-1:0] DIRECTION_LATCH_LOAD_RST = 6'h3f;
  localparam logic [INSTR_W-1:0] NOP_WORD = 12'h000;

  ////////////////////////////////////////////////////////////////////////////
  // opcode patterns, ? marks operand bits
  localparam logic [INSTR_W-1:0] OPC_NOP = 12'b0000_0000_0000;
  localparam logic [INSTR_W-1:0] OPC_OPTION = 12'b0000_0000_0010;
  localparam logic [INSTR_W-1:0] OPC_SLEEP = 12'b0000_0000_0011;
  localparam logic [INSTR_W-1:0] OPC_WDT = 12'b0000_0000_0100;
  localparam logic [INSTR_W-1:0] OPC_DIRECTION_LATCH_LOAD = 12'b0000_0000_0???;
  localparam logic [INSTR_W-1:0] OPC_MOVWF = 12'b0000_001?_????;
  localparam logic [INSTR_W-1:0] OPC_CLRW = 12'b0000_0100_0000;
  localparam logic [INSTR_W-1:0] OPC_CLRF = 12'b0000_011?_????;
  localparam logic [INSTR_W-1:0] OPC_SUB = 12'b0000_10??_????;
  localparam logic [INSTR_W-1:0] OPC_DEC = 12'b0000_11??_????;
  localparam logic [INSTR_W-1:0] OPC_OR = 12'b0001_00??_????;
  localparam logic [INSTR_W-1:0] OPC_AND = 12'b0001_01??_????;
  localparam logic [INSTR_W-1:0] OPC_XOR = 12'b0001_10??_????;
  localparam logic [INSTR_W-1:0] OPC_ADD = 12'b0001_11??_????;
  localparam logic [INSTR_W-1:0] OPC_MOVF = 12'b0010_00??_????;
  localparam logic [INSTR_W-1:0] OPC_COM = 12'b0010_01??_????;
  localparam logic [INSTR_W-1:0] OPC_INC = 12'b0010_10??_????;
  localparam logic [INSTR_W-1:0] OPC_DECSZ = 12'b0010_11??_????;
  localparam logic [INSTR_W-1:0] OPC_RRC = 12'b0011_00??_????;
  localparam logic [INSTR_W-1:0] OPC_RLC = 12'b0011_01??_????;
  localparam logic [INSTR_W-1:0] OPC_SWAP = 12'b0011_10??_????;
  localparam logic [INSTR_W-1:0] OPC_INCSZ = 12'b0011_11??_????;
  localparam logic [INSTR_W-1:0] OPC_BCLR = 12'b0100_????_????;
  localparam logic [INSTR_W-1:0] OPC_BSET = 12'b0101_????_????;
  localparam logic [INSTR_W-1:0] OPC_TSKC = 12'b0110_????_????;
  localparam logic [INSTR_W-1:0] OPC_TSKS = 12'b0111_????_????;
  localparam logic [INSTR_W-1:0] OPC_RETL = 12'b1000_????_????;
  localparam logic [INSTR_W-1:0] OPC_CALL = 12'b1001_????_????;
  localparam logic [INSTR_W-1:0] OPC_BRANCH = 12'b101?_????_????;
  localparam logic [INSTR_W-1:0] OPC_MOVL = 12'b1100_????_????;
  localparam logic [INSTR_W-1:0] OPC_ORL = 12'b1101_????_????;
  localparam logic [INSTR_W-1:0] OPC_ANDL = 12'b1110_????_????;
  localparam logic [INSTR_W-1:0] OPC_XORL = 12'b1111_????_????;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [3:0] {
    ALU_PASS, ALU_PASS_W, ALU_ZERO, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR,
    ALU_COM, ALU_DEC, ALU_INC, ALU_RLC, ALU_RRC, ALU_SWAP, ALU_BCLR, ALU_BSET
  } tid_alu_e;

  typedef struct packed {
    tid_alu_e op;
    logic use_lit;
    logic wr_w;
    logic wr_f;
    logic upd_z;
    logic upd_c;
    logic upd_dc;
    logic skip_zero;
    logic skip_clr;
    logic skip_set;
    logic branch;
    logic call;
    logic ret;
    logic option;
    logic sleep;
    logic wdt;
    logic direction_latch_load;
  } tid_dec_s;

  typedef struct packed {
    logic [GPIO_W-1:0] out;
    logic [GPIO_W-1:0] oe;
  } tid_pin_s;

  typedef struct packed {
    logic [DATA_W-1:0] acc;
    logic [DATA_W-1:0] status;
    logic [DATA_W-1:0] option;
    logic [DATA_W-1:0] timer;
  } tid_view_s;

endpackage : tid_pkg

// file: hdl/tid_alu.sv
`timescale 1ns/1ns
`default_nettype none

module tid_alu (
  // operation
  input wire tid_pkg::tid_alu_e op,
  input wire logic [tid_pkg::BITSEL_W-1:0] bit_sel,
  // operands
  input wire logic [tid_pkg::DATA_W-1:0] opd,
  input wire logic [tid_pkg::DATA_W-1:0] acc,
  input wire logic carry_in,
  // result
  output logic [tid_pkg::DATA_W-1:0] res,
  output logic carry,
  output logic dcarry,
  output logic zero
);
  import tid_pkg::*;

  // carry out of the low nibble, a + b + cin
  function automatic logic nib_carry(input logic [NIB_W-1:0] a, input logic [NIB_W-1:0] b,
                                     input logic cin);
    logic [NIB_W:0] s;
    s = {1'b0, a} + {1'b0, b} + {{NIB_W{1'b0}}, cin};
    return s[NIB_W];
  endfunction : nib_carry

  logic [DATA_W:0] sum;
  logic [DATA_W-1:0] mask;

  always_comb begin
    sum = {1'b0, opd} + {1'b0, acc};
    mask = DATA_W'(1) << bit_sel;
    res = opd;
    carry = carry_in;
    dcarry = 1'b0;
    case (op)
      ALU_PASS: res = opd;
      ALU_PASS_W: res = acc;
      ALU_ZERO: res = '0;
      ALU_ADD: begin
        res = sum[DATA_W-1:0];
        carry = sum[DATA_W];
        dcarry = nib_carry(opd[NIB_W-1:0], acc[NIB_W-1:0], 1'b0);
      end
      // carry set means no borrow
      ALU_SUB: begin
        sum = {1'b0, opd} + {1'b0, ~acc} + (DATA_W+1)'(1);
        res = sum[DATA_W-1:0];
        carry = sum[DATA_W];
        dcarry = nib_carry(opd[NIB_W-1:0], ~acc[NIB_W-1:0], 1'b1);
      end
      ALU_AND: res = opd & acc;
      ALU_OR: res = opd | acc;
      ALU_XOR: res = opd ^ acc;
      ALU_COM: res = ~opd;
      ALU_DEC: res = opd - DATA_W'(1);
      ALU_INC: res = opd + DATA_W'(1);
      ALU_RLC: begin
        res = {opd[MSB_BIT-1:0], carry_in};
        carry = opd[MSB_BIT];
      end
      ALU_RRC: begin
        res = {carry_in, opd[MSB_BIT:1]};
        carry = opd[0];
      end
      ALU_SWAP: res = {opd[NIB_W-1:0], opd[MSB_BIT:NIB_W]};
      ALU_BCLR: res = opd & ~mask;
      ALU_BSET: res = opd | mask;
      default: res = opd;
    endcase
    zero = (res == '0);
  end

endmodule : tid_alu

`default_nettype wire

// file: bench/tid_chk_checker.sv
`timescale 1ns/1ns
`default_nettype none
module tid_chk #(
  parameter int PC_W = 9,
  parameter logic [PC_W-1:0] RESET_VEC = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic clk_en,
  // program side
  input wire logic [PC_W-1:0] prog_addr,
  input wire logic [tid_pkg::INSTR_W-1:0] prog_data,
  // controls and state
  input wire logic standby,
  input wire logic wdt_clear,
  input wire logic prescaler_clear,
  input wire tid_pkg::tid_view_s view
);
  import tid_pkg::*;
  ////////////////////////////////////////
  // shadow phase: exec edge is every 4th enabled edge after release, frozen in standby
  logic [1:0] ph_ff;
  logic [INSTR_W-1:0] fetch_ff;
  wire logic exec = (ph_ff == 2'h3) && !standby && clk_en;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) ph_ff <= 2'h0;
    else if (clk_en && !standby) ph_ff <= ph_ff + 2'h1;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) fetch_ff <= NOP_WORD;
    else if (exec) fetch_ff <= prog_data;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_hold3;
    $stable(prog_addr) [*3];
  endsequence
  // the word that executes was fetched one exec earlier, hence the $past
  a_ninth_bit: assert property (
    $changed(prog_addr) && prog_addr != $past(prog_addr) + 1'b1
    && $past(fetch_ff[11:9]) != 3'h5 |-> !prog_addr[8]) else $error("pc bit 8 not cleared");
  a_pc_spacing: assert property (
    $changed(prog_addr) |=> s_hold3) else $error("pc moved inside a cycle");
  a_acc_exec: assert property (
    $changed(view.acc) |-> $past(exec)) else $error("acc changed off exec edge");
  a_wdt_pulse: assert property (
    wdt_clear && clk_en |=> !wdt_clear) else $error("wdt strobe too long");
  a_sleep_strobe: assert property (
    $rose(standby) |-> wdt_clear) else $error("sleep without wdt strobe");
  a_standby_hold: assert property (
    standby && $past(standby) |-> $stable(prog_addr)) else $error("pc moved in standby");
  a_psc_pulse: assert property (
    prescaler_clear && clk_en |=> !prescaler_clear) else $error("prescaler strobe too long");
  a_psc_cause: assert property (
    prescaler_clear |-> $past(exec) && !$past(view.option[OPT_PSA]))
    else $error("prescaler clear without cause");
endmodule : tid_chk
`default_nettype wire

// file: bench/tid_rom.sv
`timescale 1ns/1ns
`default_nettype none
// combinational program store, always selected, so no idle pattern
module tid_rom #(
  parameter int PC_W = 9
) (
  input wire logic [PC_W-1:0] addr,
  output logic [tid_pkg::INSTR_W-1:0] data
);
  import tid_pkg::*;
  logic [INSTR_W-1:0] mem [2**PC_W];
  initial for (int i = 0; i < 2**PC_W; i++) mem[i] = NOP_WORD;
  assign data = mem[addr];
endmodule : tid_rom
`default_nettype wire

// file: bench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import tid_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  logic wake_req = 1'b0;
  logic [GPIO_W-1:0] gpio_in = 6'h2a;
  logic [8:0] prog_addr;
  logic [INSTR_W-1:0] prog_data;
  logic standby;
  logic wdt_clear;
  logic psc_clr;
  tid_pin_s pin;
  tid_view_s view;
  int bad_count = 0;
  int tests_run = 0;
  int psc_seen = 0;
  int wdt_seen = 0;
  // {addr, word}: alu, skip, call, watchdog, file ops, branch, port, sleep
  logic [20:0] prog [33] = '{21'h00c17, 21'h01028, 21'h02cc2, 21'h031c8, 21'h04e5f,
    21'h05f59, 21'h06d80, 21'h07029, 21'h087e9, 21'h09c11, 21'h0a4e9, 21'h0b209,
    21'h0c920, 21'h0d1e8, 21'h0e208, 21'h0f348, 21'h10328, 21'h112e9, 21'h123e9,
    21'h13c77, 21'h142a9, 21'h15169, 21'h16128, 21'h17188, 21'h18c53, 21'h19b00,
    21'h20002, 21'h21021, 21'h22004, 21'h2383c, 21'h100006, 21'h101206, 21'h102003};
  always #5 clk = ~clk;
  tid_core dut (.clk(clk), .rstn(rstn), .clk_en(clk_en), .prog_addr(prog_addr),
    .prog_data(prog_data), .gpio_in(gpio_in), .gpio_pin(pin), .wake_req(wake_req),
    .standby(standby), .wdt_clear(wdt_clear), .prescaler_clear(psc_clr), .view(view));
  tid_rom rom (.addr(prog_addr), .data(prog_data));
  always @(posedge clk) if (psc_clr === 1'b1) psc_seen++;
  always @(posedge clk) if (wdt_clear === 1'b1) wdt_seen++;
  ////////////////////////////////////////
  task automatic test_done();
    if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // reaching address a means everything before a-1 has executed
  task automatic run_to(input logic [8:0] a);
    int n;
    n = 0;
    while (prog_addr !== a && n < 600) begin
      @(negedge clk);
      n++;
    end
    if (prog_addr !== a) begin
      bad_count++;
      test_done();
    end
  endtask : run_to
  task automatic wait_sb(input logic v);
    int n;
    n = 0;
    while (standby !== v && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (standby !== v) begin
      bad_count++;
      test_done();
    end
    chk(12'(standby), 12'(v));
  endtask : wait_sb
  task automatic t_alu();
    run_to(9'h005);
    chk(12'(view.acc), 12'h0d9);
    chk(12'(view.status), 12'h018);
    clk_en = 1'b0;
    repeat (8) @(negedge clk);
    chk(12'(prog_addr), 12'h005);
    clk_en = 1'b1;
    run_to(9'h007);
    chk(12'(view.acc), 12'h000);
    chk(12'(view.status), 12'h01c);
  endtask : t_alu
  task automatic t_skip();
    run_to(9'h00c);
    chk(12'(view.acc), 12'h080);
    run_to(9'h00d);
    chk(12'(view.acc), 12'h000);
    chk(12'(view.status), 12'h01c);
  endtask : t_skip
  task automatic t_call();
    run_to(9'h00e);
    chk(12'(view.acc), 12'h03c);
    chk(12'(view.option), 12'h000);
    chk(12'(psc_seen), 12'h001);
    chk(12'(wdt_seen), 12'h001);
  endtask : t_call
  task automatic t_file();
    run_to(9'h011);
    chk(12'(view.acc), 12'h0a6);
    chk(12'(view.status), 12'h01a);
    run_to(9'h012);
    chk(12'(view.status), 12'h01b);
    run_to(9'h016);
    chk(12'(view.acc), 12'h0a6);
    chk(12'(view.status), 12'h01b);
    run_to(9'h017);
    chk(12'(view.status), 12'h01f);
    run_to(9'h019);
    chk(12'(view.acc), 12'h009);
    run_to(9'h100);
    chk(12'(view.acc), 12'h053);
  endtask : t_file
  task automatic t_port_sleep();
    logic [8:0] held;
    run_to(9'h102);
    chk(12'(pin.oe), 12'h02c);
    run_to(9'h103);
    chk(12'(view.acc), 12'h02a);
    wait_sb(1'b1);
    chk(12'(view.status), 12'h013);
    held = prog_addr;
    repeat (20) @(negedge clk);
    chk(12'(prog_addr), 12'(held));
    chk(12'(wdt_seen), 12'h002);
    wake_req = 1'b1;
    wait_sb(1'b0);
    rstn = 1'b0;
    @(negedge clk);
    chk(12'(view.acc), 12'h000);
    chk(12'(view.status), 12'h018);
    chk(12'(prog_addr), 12'h000);
    chk(12'(view.option), 12'h0ff);
    chk(12'(pin.oe), 12'h000);
  endtask : t_port_sleep
  initial begin
    @(negedge clk);
    foreach (prog[i]) rom.mem[prog[i][20:12]] = prog[i][11:0];
    @(negedge clk);
    rstn = 1'b1;
    t_alu();
    t_skip();
    t_call();
    t_file();
    t_port_sleep();
    test_done();
  end
endmodule : tb_top
bind tid_core tid_chk #(.PC_W(PC_W), .RESET_VEC(RESET_VEC)) u_chk (.clk(clk), .rstn(rstn),
  .clk_en(clk_en), .prog_addr(prog_addr), .prog_data(prog_data), .standby(standby),
  .wdt_clear(wdt_clear), .prescaler_clear(prescaler_clear), .view(view));
`default_nettype wire
